// >>> logic/pidaux_defines.svh
`ifndef PIDAUX_DEFINES_SVH
`define PIDAUX_DEFINES_SVH
// Contract
// - start or enable preloads the integral term
// - trim mode clamps output between trim limits
// - integral frozen while output sits at limit; the code holds back only error that pushes further into the limit
// - proportional term is gain times error
// - zero proportional gain removes proportional term
// - integral reaches full scale in integral time
// - zero integral time disables integral term
// - derivative uses previous minus current error
// - derivative gain one gives 0.1 percent
// - derivative gain resets to zero, zero disables
// - at most three line-started auxiliary motors
// - staging only in mode one, count configured
// - stage on after above-threshold start delay
// - stage off after below-threshold stop delay
// - drive speed compensates added or removed motor
// - interlocked motors are skipped as out of service
// - rotation swap break-before-make contactor sequence
// - swap postponed until output below ceiling
// - relays energized after power-up by default
// - never close drive and line contactor together
// - errors inside the ignore band are dropped

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define PIDAUX_CLK_MHZ 50
`define PIDAUX_TICK_US 10000
`define PIDAUX_TICK_CYCLES (`PIDAUX_TICK_US * `PIDAUX_CLK_MHZ)
// integral time is held in tenths of a second
`define PIDAUX_TICKS_PER_TENTH (100000 / `PIDAUX_TICK_US)

// -----------------------------------------------------------------
// scaling: 10000 counts = 100.00 % of maximum frequency
// -----------------------------------------------------------------
`define PIDAUX_FULL_SCALE 16'h2710
`define PIDAUX_KP_DIV 100
`define PIDAUX_KD_DIV 10

// -----------------------------------------------------------------
// register byte addresses
// -----------------------------------------------------------------
`define PIDAUX_A_CTRL 8'h00
`define PIDAUX_A_LAST_RW 8'h38
`define PIDAUX_A_STATUS 8'h3C
`define PIDAUX_A_FREQ 8'h40
// word indices of the writable registers
`define PIDAUX_I_CTRL 0
`define PIDAUX_I_PGAIN 1
`define PIDAUX_I_ITIME 2
`define PIDAUX_I_DRATE 3
`define PIDAUX_I_BAND 4
`define PIDAUX_I_PRELOAD 5
`define PIDAUX_I_TRIM_HI 6
`define PIDAUX_I_TRIM_LO 7
`define PIDAUX_I_ON_FREQ 8
`define PIDAUX_I_OFF_FREQ 9
`define PIDAUX_I_START_DLY 10
`define PIDAUX_I_STOP_DLY 11
`define PIDAUX_I_SWAP_CEIL 12
`define PIDAUX_I_SWAP_INTV 13
`define PIDAUX_I_COMP 14
`define PIDAUX_NUM_RW 15

// control register fields
`define PIDAUX_F_RUN 0
`define PIDAUX_F_TRIM 1
`define PIDAUX_F_QTY_LO 2
`define PIDAUX_F_QTY_HI 3
`define PIDAUX_F_MODE_LO 4
`define PIDAUX_F_MODE_HI 5
`define PIDAUX_MODE_STAGING 2'h1

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define PIDAUX_RV_CTRL 16'h0000
`define PIDAUX_RV_PGAIN 16'h0064
`define PIDAUX_RV_ITIME 16'h0014
`define PIDAUX_RV_DRATE 16'h0000
`define PIDAUX_RV_BAND 16'h0000
`define PIDAUX_RV_PRELOAD 16'h0000
`define PIDAUX_RV_TRIM_HI 16'h2710
`define PIDAUX_RV_TRIM_LO 16'h0000
`define PIDAUX_RV_ON_FREQ 16'h2328
`define PIDAUX_RV_OFF_FREQ 16'h07D0
`define PIDAUX_RV_START_DLY 16'h0064
`define PIDAUX_RV_STOP_DLY 16'h0064
`define PIDAUX_RV_SWAP_CEIL 16'h1388
`define PIDAUX_RV_SWAP_INTV 16'h0000
`define PIDAUX_RV_COMP 16'h0FA0

`endif

// >>> logic/pidaux_pkg.sv
package pidaux_pkg;
   typedef enum logic [2:0] {
      SW_IDLE,
      SW_STOP,
      SW_OPEN_LINE,
      SW_CLOSE,
      SW_LINE_START
   } pidaux_swap_t;
   typedef logic [15:0] pidaux_word_t;
endpackage

// >>> logic/pidaux_tick.sv
`timescale 1ns/1ns
module pidaux_tick #(
   parameter int CYCLES = 500000
) (
   input wire logic clk,
   input wire logic nrst,
   output logic tick
);
   logic [31:0] cnt;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cnt <= 32'h0;
         tick <= 1'b0;
      end else if (cnt >= 32'(CYCLES - 1)) begin
         cnt <= 32'h0;
         tick <= 1'b1;
      end else begin
         cnt <= cnt + 32'h1;
         tick <= 1'b0;
      end
   end
endmodule

// >>> logic/pidaux_pid.sv
`timescale 1ns/1ns
`include "pidaux_defines.svh"
module pidaux_pid #(
   parameter int W = 16,
   parameter int TPT = 10
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic tick,
   input wire logic enable,
   input wire logic trim_mode,
   input wire logic [W-1:0] reference,
   input wire logic [W-1:0] feedback,
   input wire logic [W-1:0] kp,
   input wire logic [W-1:0] ti,
   input wire logic [W-1:0] kd,
   input wire logic [W-1:0] band,
   input wire logic [W-1:0] preload,
   input wire logic [W-1:0] trim_hi,
   input wire logic signed [W-1:0] trim_lo,
   input wire logic bump_down,
   input wire logic bump_up,
   input wire logic [W-1:0] bump_amt,
   output logic signed [W:0] out,
   output logic at_limit
);
   logic signed [47:0] integ;
   logic signed [W:0] err_prev;
   logic en_q, sat;
   logic signed [W:0] err_raw, err;
   logic signed [47:0] e48, ti48, p_term, i_term, d_term, sum, hi, lo, clamped;

   always_comb begin
      err_raw = $signed({1'b0, reference}) - $signed({1'b0, feedback});
      // small errors around the reference are ignored
      if ((err_raw < 0 ? -err_raw : err_raw) <= $signed({1'b0, band}))
         err = '0;
      else
         err = err_raw;
      e48 = 48'(err);
      ti48 = $signed(48'(ti)) * $signed(48'(TPT));
      p_term = (kp == '0) ? 48'sh0 : (e48 * $signed(48'(kp))) / 48'sd100;
      i_term = (ti == '0) ? 48'sh0 : integ / ti48;
      // per-tick difference of 10 ms: gain one gives 0.1 % per 1 % error change within one tick, i.e. per 100 %/s
      d_term = (kd == '0) ? 48'sh0 : ((48'(err_prev) - e48) * $signed(48'(kd))) / 48'sd10;
      sum = p_term + i_term + d_term;
      hi = trim_mode ? $signed(48'(trim_hi)) : $signed(48'(`PIDAUX_FULL_SCALE));
      lo = trim_mode ? 48'(trim_lo) : 48'sh0;
      sat = 1'b0;
      clamped = sum;
      if (sum >= hi) begin
         clamped = hi;
         sat = 1'b1;
      end else if (sum <= lo) begin
         clamped = lo;
         sat = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         en_q <= 1'b0;
      end else begin
         en_q <= enable;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || !enable) begin
         integ <= 48'sh0;
         err_prev <= '0;
         out <= '0;
         at_limit <= 1'b0;
      end else if (!en_q) begin
         // command jumps straight to the preload on every start
         integ <= $signed(48'(preload)) * ti48;
         out <= $signed({1'b0, preload});
         err_prev <= err;
      end else if (bump_down || bump_up) begin
         // shifting the integral moves the command without a windup kick
         if (bump_down)
            integ <= integ - $signed(48'(bump_amt)) * ti48;
         else
            integ <= integ + $signed(48'(bump_amt)) * ti48;
      end else if (tick) begin
         out <= clamped[W:0];
         at_limit <= sat;
         err_prev <= err;
         // only the push further into a limit is held back; a fully frozen integrator could never leave it
         if (ti != '0 && (!sat || (sum >= hi ? err < 0 : err > 0)))
            integ <= integ + e48;
      end
   end
endmodule

// >>> logic/pidaux_top.sv
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "pidaux_defines.svh"
module pidaux_top #(
   parameter int TICK_CYCLES = `PIDAUX_TICK_CYCLES,
   parameter int NMOT = 4
) (
   input wire logic SYS_CLK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [15:0] PROC_REF,
   input wire logic [15:0] PROC_FBK,
   input wire logic [NMOT-1:0] MOTOR_INTERLOCK,
   output logic signed [16:0] FREQ_CMD,
   output logic DRIVE_RUN,
   output logic [NMOT-1:0] DRIVE_CONTACTOR,
   output logic [NMOT-1:0] LINE_CONTACTOR
);
   // -----------------------------------------------------------------
   // register file
   // -----------------------------------------------------------------
   pidaux_pkg::pidaux_word_t cfg [0:`PIDAUX_NUM_RW-1];
   logic setup, access, mapped_rw, mapped;
   logic [31:0] rd_mux;
   logic [31:0] status_word;

   function automatic pidaux_pkg::pidaux_word_t cfg_reset(input int i);
      case (i)
         `PIDAUX_I_CTRL: cfg_reset = `PIDAUX_RV_CTRL;
         `PIDAUX_I_PGAIN: cfg_reset = `PIDAUX_RV_PGAIN;
         `PIDAUX_I_ITIME: cfg_reset = `PIDAUX_RV_ITIME;
         `PIDAUX_I_DRATE: cfg_reset = `PIDAUX_RV_DRATE;
         `PIDAUX_I_BAND: cfg_reset = `PIDAUX_RV_BAND;
         `PIDAUX_I_PRELOAD: cfg_reset = `PIDAUX_RV_PRELOAD;
         `PIDAUX_I_TRIM_HI: cfg_reset = `PIDAUX_RV_TRIM_HI;
         `PIDAUX_I_TRIM_LO: cfg_reset = `PIDAUX_RV_TRIM_LO;
         `PIDAUX_I_ON_FREQ: cfg_reset = `PIDAUX_RV_ON_FREQ;
         `PIDAUX_I_OFF_FREQ: cfg_reset = `PIDAUX_RV_OFF_FREQ;
         `PIDAUX_I_START_DLY: cfg_reset = `PIDAUX_RV_START_DLY;
         `PIDAUX_I_STOP_DLY: cfg_reset = `PIDAUX_RV_STOP_DLY;
         `PIDAUX_I_SWAP_CEIL: cfg_reset = `PIDAUX_RV_SWAP_CEIL;
         `PIDAUX_I_SWAP_INTV: cfg_reset = `PIDAUX_RV_SWAP_INTV;
         `PIDAUX_I_COMP: cfg_reset = `PIDAUX_RV_COMP;
         default: cfg_reset = 16'h0000;
      endcase
   endfunction

   assign setup = PSEL && !PENABLE;
   assign access = PSEL && PENABLE;
   assign mapped_rw = (PADDR[1:0] == 2'h0) && (PADDR <= `PIDAUX_A_LAST_RW);
   assign mapped = mapped_rw || PADDR == `PIDAUX_A_STATUS || PADDR == `PIDAUX_A_FREQ;
   // zero wait states: the read word is captured in the setup cycle
   assign PREADY = access;
   assign PSLVERR = access && !mapped;

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         for (int i = 0; i < `PIDAUX_NUM_RW; i++)
            cfg[i] <= cfg_reset(i);
      end else if (access && PWRITE && mapped_rw) begin
         cfg[PADDR[5:2]] <= PWDATA[15:0];
      end
   end

   always_comb begin
      rd_mux = 32'h0;
      if (mapped_rw)
         rd_mux = {16'h0000, cfg[PADDR[5:2]]};
      else if (PADDR == `PIDAUX_A_STATUS)
         rd_mux = status_word;
      else if (PADDR == `PIDAUX_A_FREQ)
         rd_mux = 32'(FREQ_CMD);
   end

   always_ff @(posedge SYS_CLK) begin
      if (!NRST)
         PRDATA <= 32'h0;
      else if (setup && !PWRITE)
         PRDATA <= rd_mux;
   end

   // -----------------------------------------------------------------
   // configuration fields
   // -----------------------------------------------------------------
   logic run_en, trim_mode, staging;
   logic [1:0] aux_qty;
   assign run_en = cfg[`PIDAUX_I_CTRL][`PIDAUX_F_RUN];
   assign trim_mode = cfg[`PIDAUX_I_CTRL][`PIDAUX_F_TRIM];
   assign aux_qty = cfg[`PIDAUX_I_CTRL][`PIDAUX_F_QTY_HI:`PIDAUX_F_QTY_LO];
   assign staging = cfg[`PIDAUX_I_CTRL][`PIDAUX_F_MODE_HI:`PIDAUX_F_MODE_LO] == `PIDAUX_MODE_STAGING;

   // -----------------------------------------------------------------
   // sample tick and regulator
   // -----------------------------------------------------------------
   logic tick;
   logic bump_down, bump_up, at_limit;

   pidaux_tick #(.CYCLES(TICK_CYCLES)) u_tick (
      .clk(SYS_CLK),
      .nrst(NRST),
      .tick(tick)
   );

   pidaux_pid #(.W(16), .TPT(`PIDAUX_TICKS_PER_TENTH)) u_pid (
      .clk(SYS_CLK),
      .nrst(NRST),
      .tick(tick),
      .enable(DRIVE_RUN),
      .trim_mode(trim_mode),
      .reference(PROC_REF),
      .feedback(PROC_FBK),
      .kp(cfg[`PIDAUX_I_PGAIN]),
      .ti(cfg[`PIDAUX_I_ITIME]),
      .kd(cfg[`PIDAUX_I_DRATE]),
      .band(cfg[`PIDAUX_I_BAND]),
      .preload(cfg[`PIDAUX_I_PRELOAD]),
      .trim_hi(cfg[`PIDAUX_I_TRIM_HI]),
      .trim_lo(cfg[`PIDAUX_I_TRIM_LO]),
      .bump_down(bump_down),
      .bump_up(bump_up),
      .bump_amt(cfg[`PIDAUX_I_COMP]),
      .out(FREQ_CMD),
      .at_limit(at_limit)
   );

   // -----------------------------------------------------------------
   // motor selection
   // -----------------------------------------------------------------
   // first candidate after the drive-fed motor in rotation order
   function automatic logic [2:0] pick_next(input logic [NMOT-1:0] cand, input logic [1:0] from);
      logic [1:0] j;
      pick_next = 3'h0;
      for (int k = NMOT - 1; k >= 1; k--) begin
         j = from + 2'(k);
         if (cand[j])
            pick_next = {1'b1, j};
      end
   endfunction

   logic [1:0] drive_motor;
   logic drive_conn;
   logic [NMOT-1:0] line_on, drive_oh, in_service;
   logic [2:0] line_cnt;
   logic [2:0] pick_on, pick_off, pick_swap;
   pidaux_pkg::pidaux_swap_t swap_state;

   // one-hot of the drive-fed motor and per-motor availability
   genvar g;
   generate
      for (g = 0; g < NMOT; g++) begin : g_mot
         assign drive_oh[g] = drive_motor == 2'(g);
         assign in_service[g] = !MOTOR_INTERLOCK[g];
      end
   endgenerate

   always_comb begin
      line_cnt = 3'h0;
      for (int i = 0; i < NMOT; i++)
         line_cnt = line_cnt + {2'h0, line_on[i]};
   end

   assign pick_on = pick_next(in_service & ~line_on & ~drive_oh, drive_motor);
   assign pick_off = pick_next(line_on & ~drive_oh, drive_motor);
   assign pick_swap = pick_next(in_service & ~drive_oh, drive_motor);

   // -----------------------------------------------------------------
   // staging timers
   // -----------------------------------------------------------------
   logic [15:0] on_cnt, off_cnt;
   logic above_on, below_off, stage_on, stage_off, stage_evt;

   assign above_on = FREQ_CMD > $signed({1'b0, cfg[`PIDAUX_I_ON_FREQ]});
   assign below_off = FREQ_CMD < $signed({1'b0, cfg[`PIDAUX_I_OFF_FREQ]});
   assign stage_on = tick && staging && swap_state == pidaux_pkg::SW_IDLE && DRIVE_RUN && above_on
      && on_cnt >= cfg[`PIDAUX_I_START_DLY] && {1'b0, aux_qty} > line_cnt && pick_on[2];
   assign stage_off = tick && staging && swap_state == pidaux_pkg::SW_IDLE && below_off
      && off_cnt >= cfg[`PIDAUX_I_STOP_DLY] && pick_off[2];
   assign stage_evt = stage_on || stage_off;

   always_ff @(posedge SYS_CLK) begin
      if (!NRST || !staging || stage_evt) begin
         on_cnt <= 16'h0;
         off_cnt <= 16'h0;
      end else if (tick) begin
         // a dip or rise breaks the continuous qualifying interval
         on_cnt <= !above_on ? 16'h0 : (on_cnt == 16'hFFFF ? on_cnt : on_cnt + 16'h1);
         off_cnt <= !below_off ? 16'h0 : (off_cnt == 16'hFFFF ? off_cnt : off_cnt + 16'h1);
      end
   end

   // -----------------------------------------------------------------
   // rotation timer
   // -----------------------------------------------------------------
   logic [15:0] swap_cnt;
   logic swap_pending, swap_go, was_line;

   assign swap_go = tick && staging && swap_pending && swap_state == pidaux_pkg::SW_IDLE && !stage_evt
      && FREQ_CMD < $signed({1'b0, cfg[`PIDAUX_I_SWAP_CEIL]}) && pick_swap[2];

   always_ff @(posedge SYS_CLK) begin
      if (!NRST || !staging || cfg[`PIDAUX_I_SWAP_INTV] == 16'h0) begin
         swap_cnt <= 16'h0;
         swap_pending <= 1'b0;
      end else if (swap_go) begin
         swap_cnt <= 16'h0;
         swap_pending <= 1'b0;
      end else if (tick && !swap_pending) begin
         if (swap_cnt + 16'h1 >= cfg[`PIDAUX_I_SWAP_INTV]) begin
            swap_pending <= 1'b1;
            swap_cnt <= 16'h0;
         end else begin
            swap_cnt <= swap_cnt + 16'h1;
         end
      end
   end

   // -----------------------------------------------------------------
   // contactor sequencer, one step per tick
   // -----------------------------------------------------------------
   logic [1:0] swap_target;

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         swap_state <= pidaux_pkg::SW_IDLE;
         drive_motor <= 2'h0;
         drive_conn <= 1'b1;
         line_on <= '0;
         swap_target <= 2'h0;
         was_line <= 1'b0;
      end else if (!staging) begin
         swap_state <= pidaux_pkg::SW_IDLE;
         drive_conn <= 1'b1;
         line_on <= '0;
      end else if (tick) begin
         // an interlocked motor is taken off the line on the next tick
         line_on <= line_on & in_service;
         case (swap_state)
            pidaux_pkg::SW_IDLE: begin
               if (stage_on)
                  line_on[pick_on[1:0]] <= 1'b1;
               else if (stage_off)
                  line_on[pick_off[1:0]] <= 1'b0;
               else if (swap_go) begin
                  swap_target <= pick_swap[1:0];
                  swap_state <= pidaux_pkg::SW_STOP;
               end
            end
            pidaux_pkg::SW_STOP: begin
               drive_conn <= 1'b0;
               swap_state <= pidaux_pkg::SW_OPEN_LINE;
            end
            pidaux_pkg::SW_OPEN_LINE: begin
               was_line <= line_on[swap_target];
               line_on[swap_target] <= 1'b0;
               swap_state <= pidaux_pkg::SW_CLOSE;
            end
            pidaux_pkg::SW_CLOSE: begin
               // line contactor was opened a full tick earlier: break before make
               drive_motor <= swap_target;
               drive_conn <= 1'b1;
               swap_state <= pidaux_pkg::SW_LINE_START;
            end
            pidaux_pkg::SW_LINE_START: begin
               if (was_line && pick_on[2])
                  line_on[pick_on[1:0]] <= 1'b1;
               swap_state <= pidaux_pkg::SW_IDLE;
            end
            default: swap_state <= pidaux_pkg::SW_IDLE;
         endcase
      end
   end

   // staging a motor shifts the drive command by one motor's share
   assign bump_down = stage_on;
   assign bump_up = stage_off;

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   logic drive_run_q;
   logic [NMOT-1:0] drive_ct_q, line_ct_q;

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         drive_run_q <= 1'b0;
         drive_ct_q <= '0;
         line_ct_q <= '1;
      end else if (!staging) begin
         // relays not assigned to staging stay energized, drive contactors open
         drive_run_q <= run_en;
         drive_ct_q <= '0;
         line_ct_q <= '1;
      end else begin
         // restarting after a swap gives the regulator a fresh preload
         drive_run_q <= run_en && drive_conn && swap_state != pidaux_pkg::SW_STOP;
         drive_ct_q <= drive_conn ? drive_oh : '0;
         line_ct_q <= line_on & ~(drive_conn ? drive_oh : '0);
      end
   end

   assign DRIVE_RUN = drive_run_q;
   assign DRIVE_CONTACTOR = drive_ct_q;
   assign LINE_CONTACTOR = line_ct_q;

   assign status_word = {16'h0000, 3'h0, at_limit, swap_pending, swap_state, line_on[3:0],
                         drive_conn, 1'b0, drive_motor};
endmodule

// >>> tb/pidaux_contactor_model.sv
`timescale 1ns/1ns
module pidaux_contactor_model (
   input wire logic clk,
   input wire logic [3:0] drive_close,
   input wire logic [3:0] line_close,
   input wire logic [3:0] oos,
   output logic [3:0] interlock,
   output logic weld
);
   // ------------------------------------------------------------
   // contactor armatures lag the relay coils by one cycle
   // ------------------------------------------------------------
   logic [3:0] drv_q = 4'h0;
   logic [3:0] line_q = 4'h0;
   initial weld = 1'b0;
   always @(posedge clk) begin
      drv_q <= drive_close;
      line_q <= line_close;
      if (|(drv_q & line_q)) begin
         weld <= 1'b1;
      end
   end
   // a motor fed from both sides trips its overload and drops out of service
   assign interlock = oos | (drv_q & line_q);
endmodule

// >>> tb/pidaux_properties.sv
`timescale 1ns/1ns
module pidaux_properties #(
   parameter int TICK_CYCLES = 20,
   parameter int NMOT = 4
) (
   input wire logic SYS_CLK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic [7:0] PADDR,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic [NMOT-1:0] MOTOR_INTERLOCK,
   input wire logic signed [16:0] FREQ_CMD,
   input wire logic DRIVE_RUN,
   input wire logic [NMOT-1:0] DRIVE_CONTACTOR,
   input wire logic [NMOT-1:0] LINE_CONTACTOR
);
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!NRST);
   logic mapped;
   assign mapped = PADDR <= 8'h40 && PADDR[1:0] == 2'h0;
   chk_no_dual_close: assert property ((DRIVE_CONTACTOR & LINE_CONTACTOR) == '0)
      else $error("drive and line contactor closed together");
   chk_relays_reset: assert property ($rose(NRST) |-> LINE_CONTACTOR == '1 && DRIVE_CONTACTOR == '0)
      else $error("relays not energized after reset");
   chk_reset_clear: assert property ($rose(NRST) |-> FREQ_CMD == '0 && !DRIVE_RUN)
      else $error("regulator not cleared by reset");
   chk_swap_break: assert property ($past(DRIVE_CONTACTOR) != '0 && DRIVE_CONTACTOR != '0 |->
      DRIVE_CONTACTOR == $past(DRIVE_CONTACTOR))
      else $error("drive contactor moved without opening");
   chk_stop_on_open: assert property ($fell(DRIVE_CONTACTOR != '0) |-> !DRIVE_RUN)
      else $error("drive running while its contactor opens");
   chk_drive_onehot: assert property ($onehot0(DRIVE_CONTACTOR))
      else $error("more than one drive-fed motor");
   chk_stage_one: assert property ($countones(LINE_CONTACTOR & ~$past(LINE_CONTACTOR)) <= 1)
      else $error("two motors line-started at once");
   chk_skip_locked: assert property ((LINE_CONTACTOR & ~$past(LINE_CONTACTOR) & MOTOR_INTERLOCK
      & $past(MOTOR_INTERLOCK, 3)) == '0)
      else $error("interlocked motor line-started");
   chk_ready_now: assert property (PREADY == (PSEL && PENABLE))
      else $error("ready outside the access cycle");
   chk_err_unmapped: assert property (PSEL && PENABLE && !mapped |-> PSLVERR)
      else $error("unmapped access not flagged");
   chk_err_mapped: assert property (PSEL && PENABLE && mapped |-> !PSLVERR)
      else $error("mapped access flagged");
endmodule
bind pidaux_top pidaux_properties #(.TICK_CYCLES(TICK_CYCLES), .NMOT(NMOT)) i_props (.SYS_CLK(SYS_CLK),
   .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .MOTOR_INTERLOCK(MOTOR_INTERLOCK), .FREQ_CMD(FREQ_CMD), .DRIVE_RUN(DRIVE_RUN),
   .DRIVE_CONTACTOR(DRIVE_CONTACTOR), .LINE_CONTACTOR(LINE_CONTACTOR));

// >>> tb/tb.sv
`timescale 1ns/1ns
`include "pidaux_defines.svh"
module tb;
   localparam int TK = 20;
   logic SYS_CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, rerr, weld, DRIVE_RUN;
   logic [7:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rdat;
   logic [15:0] PROC_REF, PROC_FBK;
   logic [3:0] oos, ilk, DRIVE_CONTACTOR, LINE_CONTACTOR;
   logic signed [16:0] FREQ_CMD, v1;
   int num_errors = 0;
   int checks = 0;
   int n;
   pidaux_top #(.TICK_CYCLES(TK), .NMOT(4)) i_dut (.SYS_CLK(SYS_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .PROC_REF(PROC_REF), .PROC_FBK(PROC_FBK), .MOTOR_INTERLOCK(ilk), .FREQ_CMD(FREQ_CMD), .DRIVE_RUN(DRIVE_RUN),
      .DRIVE_CONTACTOR(DRIVE_CONTACTOR), .LINE_CONTACTOR(LINE_CONTACTOR));
   pidaux_contactor_model i_mot (.clk(SYS_CLK), .drive_close(DRIVE_CONTACTOR), .line_close(LINE_CONTACTOR),
      .oos(oos), .interlock(ilk), .weld(weld));
   initial begin
      SYS_CLK = 1'b0;
      forever #10 SYS_CLK = ~SYS_CLK;
   end
   // ------------------------------------------------------------
   // bus and helper tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge SYS_CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge SYS_CLK);
      PENABLE <= 1'b1;
      do @(posedge SYS_CLK); while (PREADY !== 1'b1);
      rdat = PRDATA;
      rerr = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic wr(input int i, input logic [15:0] d);
      xfer(1'b1, 8'(i * 4), {16'h0000, d});
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask
   task automatic cfg(input logic [15:0] kp, ti, kd, pre);
      wr(1, kp);
      wr(2, ti);
      wr(3, kd);
      wr(5, pre);
   endtask
   task automatic run(input logic [15:0] c);
      wr(0, 16'h0000);
      wr(0, c);
   endtask
   task automatic proc(input logic [15:0] r, input logic [15:0] f);
      @(posedge SYS_CLK);
      PROC_REF <= r;
      PROC_FBK <= f;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge SYS_CLK);
   endtask
   // bounded wait for any change at the process outputs; n holds the cycles
   task automatic wait_out;
      logic [25:0] s;
      @(negedge SYS_CLK);
      s = {FREQ_CMD, DRIVE_RUN, DRIVE_CONTACTOR, LINE_CONTACTOR};
      n = 1;
      while ({FREQ_CMD, DRIVE_RUN, DRIVE_CONTACTOR, LINE_CONTACTOR} === s && n < 2000) begin
         @(negedge SYS_CLK);
         n++;
      end
      if (n >= 2000) num_errors++;
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge SYS_CLK);
      num_errors++;
      print_verdict();
   end
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      {NRST, PSEL, PENABLE, PWRITE, PADDR, PWDATA, PROC_REF, PROC_FBK, oos} = '0;
      repeat (10) @(posedge SYS_CLK);
      NRST <= 1'b1;
      rdchk(8'h00, `PIDAUX_RV_CTRL);
      rdchk(8'h04, `PIDAUX_RV_PGAIN);
      rdchk(8'h0C, `PIDAUX_RV_DRATE);
      rdchk(8'h18, `PIDAUX_RV_TRIM_HI);
      rdchk(8'h44, 32'h0);
      chk(rerr, 1'b1);
      chk(LINE_CONTACTOR, 4'hF);
      chk(DRIVE_CONTACTOR, 4'h0);
      $display("test reset done");
      cfg(16'h0000, 16'h0000, 16'h0000, 16'h0000);
      proc(16'h1388, 16'h0BB8);
      run(16'h0001);
      cyc(100);
      chk(FREQ_CMD, 32'h0);
      wr(1, 16'h0064);
      cyc(80);
      chk(FREQ_CMD, 32'h07D0);
      wr(4, 16'h0BB8);
      cyc(80);
      chk(FREQ_CMD, 32'h0);
      wr(4, 16'h0000);
      $display("test gains done");
      cfg(16'h0000, 16'h0001, 16'h0000, 16'h0000);
      wr(6, 16'h0FA0);
      wr(7, 16'hF830);
      proc(16'h2710, 16'h0000);
      run(16'h0003);
      cyc(5);
      wait_out();
      v1 = FREQ_CMD;
      wait_out();
      chk(FREQ_CMD - v1, 32'h03E8);
      cyc(300);
      chk(FREQ_CMD, 32'h0FA0);
      proc(16'h0000, 16'h2710);
      wait_out();
      chk(FREQ_CMD, 32'h0BB8);
      cyc(300);
      chk(FREQ_CMD, 32'hFFFFF830);
      $display("test integral done");
      cfg(16'h0000, 16'hFFFF, 16'h0064, 16'h1388);
      proc(16'h1770, 16'h1770);
      run(16'h0001);
      cyc(60);
      chk(FREQ_CMD, 32'h1388);
      proc(16'h1770, 16'h1766);
      wait_out();
      chk(FREQ_CMD, 32'h1324);
      wait_out();
      chk(FREQ_CMD, 32'h1388);
      $display("test derivative done");
      cfg(16'h0000, 16'hFFFF, 16'h0000, 16'h251C);
      wr(8, 16'hFFFF);
      wr(10, 16'h0003);
      wr(11, 16'h0003);
      oos <= 4'b0010;
      run(16'h001D);
      cyc(100);
      chk(DRIVE_CONTACTOR, 4'b0001);
      chk(LINE_CONTACTOR, 4'b0000);
      wr(8, 16'h2328);
      wait_out();
      chk(n >= 3 * TK, 1'b1);
      chk(LINE_CONTACTOR, 4'b0100);
      wait_out();
      chk(FREQ_CMD, 32'h157C);
      cyc(200);
      chk(LINE_CONTACTOR, 4'b0100);
      wr(8, 16'hFFFF);
      wr(9, 16'h1770);
      wait_out();
      chk(LINE_CONTACTOR, 4'b0000);
      wait_out();
      chk(FREQ_CMD, 32'h251C);
      wr(13, 16'h0002);
      cyc(200);
      chk(DRIVE_CONTACTOR, 4'b0001);
      wr(12, 16'h2710);
      wait_out();
      chk(DRIVE_RUN, 1'b0);
      for (int k = 0; k < 4 && DRIVE_CONTACTOR !== 4'b0000; k++) wait_out();
      chk(DRIVE_CONTACTOR, 4'b0000);
      for (int k = 0; k < 4 && DRIVE_CONTACTOR === 4'b0000; k++) wait_out();
      cyc(2);
      chk(DRIVE_RUN, 1'b1);
      chk(DRIVE_CONTACTOR, 4'b0100);
      $display("test staging done");
      @(posedge SYS_CLK);
      NRST <= 1'b0;
      repeat (2) @(posedge SYS_CLK);
      NRST <= 1'b1;
      cyc(1);
      chk(LINE_CONTACTOR, 4'hF);
      chk(DRIVE_RUN, 1'b0);
      chk(weld, 1'b0);
      $display("test second reset done");
      print_verdict();
   end
endmodule
